// File: src/etc_timer.sv
// Event timer/capture unit: registers, event front end, counter and output.
// Assumes sleep, debug and companion signals come from logic on i_sys_clk.
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Power-down freezes the counter and mode engine; standby freezes them unless standby run is set.
// - Standby run bit lets the timer work in standby, except with companion clock.
// - With restart follow set, companion restarts clear the counter.
// - Clock source: peripheral, half peripheral, companion tick; value 3 gives no tick.
// - Enable bit starts the timer; cleared, the timer stays idle.
// - Single-shot: early bit raises output at the event, else at counter start.
// - Initial level bit gives the output level outside single-shot and PWM.
// - Output gate bit zero forces the output low.
// - Three-bit mode field selects one of eight counting modes.
// - Filter bit enables a four-sample noise canceller on the event.
// - Periodic and PWM modes ignore all event edges.
// - Time-out check: selected edge starts the counter, the other stops it.
// - Capture mode: selected edge captures the count and sets the flag.
// - Frequency mode: selected edge captures, clears, restarts and flags.
// - Pulse-width: selected edge clears and restarts, opposite edge captures and flags.
// - Combined mode: edge restarts, opposite captures, next edge stops and flags.
// - Single-shot starts on rising edge, or either edge when edge bit set.
// - Events act only while the event input enable bit is set.
// - Flag clears on writing one, or on capture read in capture modes.
// - Every flag set also pulses the event output for one cycle.
// - Sixteen-bit registers go through one shared byte staging latch.
module etc_timer
  import etc_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_clk_en,
  input  wire logic [3:0] i_avs_address,
  input  wire logic       i_avs_read,
  input  wire logic       i_avs_write,
  input  wire logic [7:0] i_avs_writedata,
  output logic      [7:0] o_avs_readdata,
  output logic            o_avs_waitrequest,
  input  wire logic       i_sleep_standby,
  input  wire logic       i_sleep_powerdown,
  input  wire logic       i_debug_halt,
  input  wire logic       i_event,
  input  wire logic       i_comp_tick,
  input  wire logic       i_comp_restart,
  output logic            o_wave,
  output logic            o_event_strobe
);
  // ==================================================
  // Reset release
  logic rst_s1_r, rst_n;
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  end

  function automatic logic is_capture_flag(input etc_mode_t m);
    return m inside {MODE_CAPTURE, MODE_FREQ, MODE_PWIDTH, MODE_FREQ_PW};
  endfunction

  // ==================================================
  // Registers
  logic [7:0]  ctrl_a_r, ctrl_b_r, event_control_r, inten_r, dbg_r, temp_r, rdata_r;
  logic [15:0] cnt_r, capture_or_top_value_r;
  logic        flag_r, run_r, pend_r, ss_r, ack_r, half_r, wave_r, strobe_r;
  etc_fpw_t    phase_r;
  etc_bus_req_t req;
  etc_mode_t   mode;
  logic        do_wr, rd_take, flag_clr, wr_cnt, wr_capture_or_top_value;
  logic [7:0]  rd_mux;

  assign req = '{addr: i_avs_address, rd: i_avs_read, wr: i_avs_write, wdata: i_avs_writedata};
  assign mode = etc_mode_t'(ctrl_b_r[2:0]);
  // First cycle stalls, second completes: readdata is then a flop
  assign o_avs_waitrequest = (req.rd | req.wr) & ~ack_r;
  assign do_wr   = req.wr & ack_r;
  assign rd_take = req.rd & ~ack_r;
  assign wr_cnt  = do_wr && req.addr == OFS_CNT_H;
  assign wr_capture_or_top_value = do_wr && req.addr == OFS_CAPTURE_OR_TOP_VALUE_H;

  always_comb begin
    if (req.addr == OFS_CTRL_A) rd_mux = ctrl_a_r;
    else if (req.addr == OFS_CTRL_B) rd_mux = ctrl_b_r;
    else if (req.addr == OFS_EVENT_CONTROL) rd_mux = event_control_r;
    else if (req.addr == OFS_INTEN) rd_mux = inten_r;
    else if (req.addr == OFS_FLAGS) rd_mux = {7'h00, flag_r};
    else if (req.addr == OFS_STATUS) rd_mux = {7'h00, run_r};
    else if (req.addr == OFS_DEBUG_CONTROL) rd_mux = dbg_r;
    else if (req.addr == OFS_TEMP || req.addr == OFS_CNT_H || req.addr == OFS_CAPTURE_OR_TOP_VALUE_H) rd_mux = temp_r;
    else if (req.addr == OFS_CNT_L) rd_mux = cnt_r[7:0];
    else if (req.addr == OFS_CAPTURE_OR_TOP_VALUE_L) rd_mux = capture_or_top_value_r[7:0];
    else rd_mux = 8'h00;
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r   <= 1'b0;
      rdata_r <= RESET_BYTE;
    end else if (i_clk_en) begin
      ack_r <= (req.rd | req.wr) & ~ack_r;
      if (rd_take) begin
        rdata_r <= rd_mux;
      end
    end
  end
  assign o_avs_readdata = rdata_r;

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_a_r <= RESET_BYTE;
      ctrl_b_r <= RESET_BYTE;
      event_control_r <= RESET_BYTE;
      inten_r  <= RESET_BYTE;
      dbg_r    <= RESET_BYTE;
    end else if (i_clk_en && do_wr) begin
      if (req.addr == OFS_CTRL_A) ctrl_a_r <= req.wdata & MASK_CTRL_A;
      else if (req.addr == OFS_CTRL_B) ctrl_b_r <= req.wdata & MASK_CTRL_B;
      else if (req.addr == OFS_EVENT_CONTROL) event_control_r <= req.wdata & MASK_EVENT_CONTROL;
      else if (req.addr == OFS_INTEN) inten_r <= req.wdata & MASK_BIT0;
      else if (req.addr == OFS_DEBUG_CONTROL) dbg_r <= req.wdata & MASK_BIT0;
    end
  end

  // Staging latch: low byte first on both read and write
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_r <= RESET_BYTE;
    end else if (i_clk_en) begin
      if (rd_take && req.addr == OFS_CNT_L) temp_r <= cnt_r[15:8];
      else if (rd_take && req.addr == OFS_CAPTURE_OR_TOP_VALUE_L) temp_r <= capture_or_top_value_r[15:8];
      else if (do_wr && (req.addr inside {OFS_TEMP, OFS_CNT_L, OFS_CAPTURE_OR_TOP_VALUE_L})) temp_r <= req.wdata;
    end
  end

  // ==================================================
  // Run gating and clock source
  logic active, tick;
  assign active = ctrl_a_r[BIT_ENABLE] & ~i_sleep_powerdown
                & ~(i_sleep_standby & ~(ctrl_a_r[BIT_STDBY]
                    & ctrl_a_r[BIT_CLOCK_SOURCE_SELECT+:2] != CLKSRC_COMP))
                & ~(i_debug_halt & ~dbg_r[0]);
  always_comb begin
    case (ctrl_a_r[BIT_CLOCK_SOURCE_SELECT+:2])
      CLKSRC_PERIPH: tick = 1'b1;
      CLKSRC_HALF:   tick = half_r;
      CLKSRC_COMP:   tick = i_comp_tick;
      default:       tick = 1'b0;
    endcase
  end

  // ==================================================
  // Event front end
  logic ev_s1_r, ev_s2_r, filt_r, ev_prev_r, ev_now, ev_pos, ev_neg, ev_ok, st, op;
  logic [FILTER_LEN-1:0] hist_r;
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_s1_r   <= 1'b0;
      ev_s2_r   <= 1'b0;
      hist_r    <= '0;
      filt_r    <= 1'b0;
      ev_prev_r <= 1'b0;
      half_r    <= 1'b0;
    end else if (i_clk_en) begin
      ev_s1_r <= i_event;
      ev_s2_r <= ev_s1_r;
      hist_r  <= {hist_r[FILTER_LEN-2:0], ev_s2_r};
      if (&hist_r || ~|hist_r) begin
        filt_r <= hist_r[0];
      end
      ev_prev_r <= ev_now;
      half_r    <= ~half_r;
    end
  end
  assign ev_now = event_control_r[BIT_FILTER] ? filt_r : ev_s2_r;
  assign ev_pos = ev_now & ~ev_prev_r;
  assign ev_neg = ~ev_now & ev_prev_r;
  assign ev_ok  = event_control_r[BIT_EVIN] & active;
  assign st = ev_ok & (event_control_r[BIT_EDGE] ? ev_neg : ev_pos);
  assign op = ev_ok & (event_control_r[BIT_EDGE] ? ev_pos : ev_neg);

  // ==================================================
  // Mode engine
  logic [15:0] cnt_nxt, top;
  logic        run_nxt, pend_nxt, cap, fset, clr, early;
  etc_fpw_t    phase_nxt;
  assign top = (mode == MODE_PWM8) ? {8'h00, capture_or_top_value_r[7:0]} : capture_or_top_value_r;
  always_comb begin
    cnt_nxt   = cnt_r;
    run_nxt   = run_r;
    phase_nxt = phase_r;
    pend_nxt  = 1'b0;
    cap = 1'b0;
    fset = 1'b0;
    clr = 1'b0;
    early = 1'b0;
    if (!ctrl_a_r[BIT_ENABLE]) begin
      run_nxt   = 1'b0;
      phase_nxt = FPW_WAIT;
    end else if (active) begin
      case (mode)
        MODE_TIMEOUT: begin
          if (st) run_nxt = 1'b1;
          else if (op) run_nxt = 1'b0;
        end
        MODE_CAPTURE: begin
          run_nxt = 1'b1;
          cap  = st;
          fset = st;
        end
        MODE_FREQ: begin
          run_nxt = 1'b1;
          cap  = st;
          fset = st;
          clr  = st;
        end
        MODE_PWIDTH: begin
          run_nxt = 1'b1;
          clr  = st;
          cap  = op;
          fset = op;
        end
        MODE_FREQ_PW: begin
          case (phase_r)
            FPW_WAIT: if (st) begin
              clr = 1'b1;
              run_nxt = 1'b1;
              phase_nxt = FPW_HIGH;
            end
            FPW_HIGH: if (op) begin
              cap = 1'b1;
              phase_nxt = FPW_LOW;
            end
            FPW_LOW: if (st) begin
              run_nxt = 1'b0;
              fset = 1'b1;
              phase_nxt = FPW_DONE;
            end
            default: if (!flag_r) begin
              phase_nxt = FPW_WAIT;
            end
          endcase
        end
        MODE_SINGLE: begin
          if (!run_r && !pend_r && ev_ok && (ev_pos || (event_control_r[BIT_EDGE] && ev_neg))) begin
            pend_nxt = 1'b1;
            early    = ctrl_b_r[BIT_EARLY];
          end
          if (pend_r) begin
            run_nxt = 1'b1;
            clr     = 1'b1;
          end
        end
        default: run_nxt = 1'b1;
      endcase
      if (clr) cnt_nxt = RESET_WORD;
      else if (run_r && tick) begin
        if (is_capture_flag(mode) || cnt_r != top) begin
          cnt_nxt = cnt_r + 16'h0001;
        end else begin
          fset    = 1'b1;
          cnt_nxt = RESET_WORD;
          if (mode == MODE_SINGLE) begin
            run_nxt = 1'b0;
            cnt_nxt = cnt_r;
          end
        end
      end
      if (ctrl_a_r[BIT_FOLLOW] && i_comp_restart) cnt_nxt = RESET_WORD;
    end
  end

  // Software write wins over the engine
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r   <= RESET_WORD;
      capture_or_top_value_r  <= RESET_WORD;
      run_r   <= 1'b0;
      pend_r  <= 1'b0;
      phase_r <= FPW_WAIT;
    end else if (i_clk_en) begin
      cnt_r   <= wr_cnt ? {req.wdata, temp_r} : cnt_nxt;
      capture_or_top_value_r  <= wr_capture_or_top_value ? {req.wdata, temp_r} : (cap ? cnt_r : capture_or_top_value_r);
      run_r   <= run_nxt;
      pend_r  <= pend_nxt;
      phase_r <= phase_nxt;
    end
  end

  // Set wins over clear
  assign flag_clr = (do_wr && req.addr == OFS_FLAGS && req.wdata[0])
                  || (rd_take && req.addr == OFS_CAPTURE_OR_TOP_VALUE_L && is_capture_flag(mode));
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r   <= 1'b0;
      strobe_r <= 1'b0;
    end else if (i_clk_en) begin
      flag_r   <= fset | (flag_r & ~flag_clr);
      strobe_r <= fset;
    end
  end
  assign o_event_strobe = strobe_r;

  // ==================================================
  // Output
  logic wave_val;
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ss_r <= 1'b0;
    end else if (i_clk_en) begin
      if (early || pend_r) ss_r <= 1'b1;
      else if (!run_nxt) ss_r <= 1'b0;
    end
  end
  always_comb begin
    case (mode)
      MODE_SINGLE: wave_val = ss_r;
      MODE_PWM8:   wave_val = ctrl_a_r[BIT_ENABLE] && cnt_r[7:0] < capture_or_top_value_r[15:8];
      default:     wave_val = ctrl_b_r[BIT_INITLVL];
    endcase
  end
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wave_r <= 1'b0;
    end else if (i_clk_en) begin
      wave_r <= ctrl_b_r[BIT_GATE] & wave_val;
    end
  end
  assign o_wave = wave_r;

  // ==================================================
  // Checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!rst_n || !i_clk_en);
  sequence s_ss_trigger;
    mode == MODE_SINGLE && active && ev_ok && !run_r && !pend_r && ev_pos;
  endsequence
  sequence s_ss_launch;
    pend_r ##1 run_r;
  endsequence
  a_strobe_flag: assert property (o_event_strobe |-> flag_r)
    else $error("strobe without flag");
  a_gate_low: assert property (!ctrl_b_r[BIT_GATE] |=> !o_wave)
    else $error("output not gated");
  a_init_level: assert property (ctrl_b_r[BIT_GATE] && mode == MODE_TIMEOUT
    |=> o_wave == $past(ctrl_b_r[BIT_INITLVL])) else $error("initial level wrong");
  a_disabled_idle: assert property (!ctrl_a_r[BIT_ENABLE] |=> !run_r)
    else $error("runs while disabled");
  a_powerdown_hold: assert property (i_sleep_powerdown && !do_wr |=> $stable(cnt_r))
    else $error("counts in power-down");
  a_ignore_events: assert property (mode inside {MODE_PERIODIC, MODE_PWM8} |-> !cap && !clr)
    else $error("event acted in periodic or pwm");
  a_event_gate: assert property (!event_control_r[BIT_EVIN] |-> !cap)
    else $error("capture with input off");
  a_capture_val: assert property (cap && !wr_capture_or_top_value |=> capture_or_top_value_r == $past(cnt_r))
    else $error("capture value wrong");
  a_flag_w1c: assert property (do_wr && req.addr == OFS_FLAGS && req.wdata[0] && !fset
    |=> !flag_r) else $error("flag not cleared");
  a_single_launch: assert property (s_ss_trigger |=> s_ss_launch)
    else $error("single-shot did not start");
  a_reserved_clk: assert property (ctrl_a_r[BIT_CLOCK_SOURCE_SELECT+:2] == 2'h3 |-> !tick)
    else $error("reserved source ticks");
  a_follow_restart: assert property (active && ctrl_a_r[BIT_FOLLOW] && i_comp_restart
    && !wr_cnt |=> cnt_r == 16'h0000) else $error("restart not followed");
endmodule
`default_nettype wire

// File: src/etc_pkg.sv
// Constants, modes and carrier types of the event timer/capture unit.
// Assumes an 8-bit register file behind a word-indexed Avalon-MM slave.
package etc_pkg;
  // ==================================================
  // Register indexes
  localparam logic [3:0] OFS_CTRL_A  = 4'h0;
  localparam logic [3:0] OFS_CTRL_B  = 4'h1;
  localparam logic [3:0] OFS_EVENT_CONTROL  = 4'h4;
  localparam logic [3:0] OFS_INTEN   = 4'h5;
  localparam logic [3:0] OFS_FLAGS   = 4'h6;
  localparam logic [3:0] OFS_STATUS  = 4'h7;
  localparam logic [3:0] OFS_DEBUG_CONTROL = 4'h8;
  localparam logic [3:0] OFS_TEMP    = 4'h9;
  localparam logic [3:0] OFS_CNT_L   = 4'ha;
  localparam logic [3:0] OFS_CNT_H   = 4'hb;
  localparam logic [3:0] OFS_CAPTURE_OR_TOP_VALUE_L  = 4'hc;
  localparam logic [3:0] OFS_CAPTURE_OR_TOP_VALUE_H  = 4'hd;
  // ==================================================
  // Field positions and writable masks
  localparam int BIT_ENABLE   = 0;
  localparam int BIT_CLOCK_SOURCE_SELECT   = 1;
  localparam int BIT_FOLLOW   = 4;
  localparam int BIT_STDBY    = 6;
  localparam int BIT_GATE     = 4;
  localparam int BIT_INITLVL  = 5;
  localparam int BIT_EARLY    = 6;
  localparam int BIT_EVIN     = 0;
  localparam int BIT_EDGE     = 4;
  localparam int BIT_FILTER   = 6;
  localparam logic [7:0] MASK_CTRL_A  = 8'h57;
  localparam logic [7:0] MASK_CTRL_B  = 8'h77;
  localparam logic [7:0] MASK_EVENT_CONTROL  = 8'h51;
  localparam logic [7:0] MASK_BIT0    = 8'h01;
  localparam logic [7:0] RESET_BYTE   = 8'h00;
  localparam logic [15:0] RESET_WORD  = 16'h0000;
  // ==================================================
  // Clock sources and filter length
  localparam logic [1:0] CLKSRC_PERIPH = 2'h0;
  localparam logic [1:0] CLKSRC_HALF   = 2'h1;
  localparam logic [1:0] CLKSRC_COMP   = 2'h2;
  localparam int         FILTER_LEN    = 4;
  typedef enum logic [2:0] {
    MODE_PERIODIC = 3'b000, MODE_TIMEOUT = 3'b001,
    MODE_CAPTURE  = 3'b010, MODE_FREQ    = 3'b011,
    MODE_PWIDTH   = 3'b100, MODE_FREQ_PW = 3'b101,
    MODE_SINGLE   = 3'b110, MODE_PWM8    = 3'b111
  } etc_mode_t;
  typedef enum logic [1:0] {
    FPW_WAIT = 2'b00, FPW_HIGH = 2'b01, FPW_LOW = 2'b10, FPW_DONE = 2'b11
  } etc_fpw_t;
  typedef struct packed {
    logic [3:0] addr;
    logic       rd;
    logic       wr;
    logic [7:0] wdata;
  } etc_bus_req_t;
endpackage

// File: verif/etc_far_model.sv
// Far-side model: event channel source and companion timer.
// Assumes its tasks are called right after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module etc_far_model
  import etc_pkg::*;
(
  input  wire logic i_sys_clk,
  output logic      o_event,
  output logic      o_comp_tick,
  output logic      o_comp_restart
);
  // ==========
  // Companion clock enable, every second cycle
  initial begin
    o_event        = 1'b0;
    o_comp_tick    = 1'b0;
    o_comp_restart = 1'b0;
  end
  always @(posedge i_sys_clk) begin
    o_comp_tick <= ~o_comp_tick;
  end
  // ==========
  // Event level and restart pulse
  task automatic set_event(input logic lvl);
    o_event <= lvl;
  endtask
  task automatic restart();
    o_comp_restart <= 1'b1;
    @(posedge i_sys_clk);
    o_comp_restart <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: verif/test_event_timer_capture_unit.sv
// Self-checking bench for the event timer/capture unit.
// Assumes etc_far_model drives the event and companion inputs.
`timescale 1ns/1ps
`default_nettype none
module test_event_timer_capture_unit
  import etc_pkg::*;
;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic       rd = 1'b0;
  logic       wr = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic       stby = 1'b0;
  logic       pdown = 1'b0;
  logic       halt = 1'b0;
  logic       hold = 1'b0;
  logic [7:0] rdata;
  logic       waitreq, ev, tick, rstrt, wave, strobe;
  int         num_errors = 0;
  int         n_checks = 0;
  int         strobes = 0;
  always #50 clk = ~clk;
  always @(negedge clk) if (strobe === 1'b1) strobes <= strobes + 1;
  etc_far_model P (.i_sys_clk(clk), .o_event(ev), .o_comp_tick(tick), .o_comp_restart(rstrt));
  etc_timer DUT (.i_sys_clk(clk), .i_reset_n(rst_n), .i_clk_en(!hold), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
    .o_avs_waitrequest(waitreq), .i_sleep_standby(stby), .i_sleep_powerdown(pdown),
    .i_debug_halt(halt), .i_event(ev), .i_comp_tick(tick), .i_comp_restart(rstrt),
    .o_wave(wave), .o_event_strobe(strobe));
  // ==========
  // Checking and bus access
  task automatic conclude();
    if (num_errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
    logic ok;
    ok = 1'b0;
    addr  <= a;
    wdata <= d;
    rd    <= ~w;
    wr    <= w;
    for (int n = 0; n < 16; n++) begin
      @(negedge clk);
      ok = (waitreq === 1'b0);
      q  = rdata;
      @(posedge clk);
      if (ok) break;
    end
    if (!ok) begin
      num_errors++;
      conclude();
    end
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr8(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd8(input logic [3:0] a, output logic [7:0] q);
    bus(1'b0, a, 8'h00, q);
  endtask
  task automatic rdc(input string nm, input logic [3:0] a, input logic [7:0] e);
    logic [7:0] q;
    rd8(a, q);
    chk(nm, q, e);
  endtask
  task automatic wr16(input logic [3:0] a, input logic [15:0] v);
    wr8(a, v[7:0]);
    wr8(a + 4'h1, v[15:8]);
  endtask
  task automatic cfg(input logic [7:0] cb, input logic [7:0] ec, input logic [15:0] top,
                     input logic [15:0] cnt);
    wr8(OFS_CTRL_A, 8'h00);
    wr8(OFS_CTRL_B, cb);
    wr8(OFS_EVENT_CONTROL, ec);
    wr16(OFS_CAPTURE_OR_TOP_VALUE_L, top);
    wr16(OFS_CNT_L, cnt);
    wr8(OFS_FLAGS, 8'h01);
    wr8(OFS_CTRL_A, 8'h01);
  endtask
  task automatic edge_to(input logic lvl, input int hold);
    P.set_event(lvl);
    repeat (hold) @(posedge clk);
  endtask
  task automatic lat(output int n);
    for (n = 1; n < 12; n++) begin
      @(negedge clk);
      if (wave === 1'b1) break;
    end
  endtask
  // ==========
  // Scenarios
  task automatic t_regs();
    logic [3:0] a [8] = '{OFS_STATUS, OFS_CTRL_A, OFS_CTRL_B, OFS_EVENT_CONTROL, OFS_INTEN, OFS_DEBUG_CONTROL, OFS_TEMP, 4'h2};
    logic [7:0] d [8] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h5a, 8'haa};
    logic [7:0] e [8] = '{8'h00, 8'h57, 8'h77, 8'h51, 8'h01, 8'h01, 8'h5a, 8'h00};
    for (int i = 0; i < 16; i++) rdc("reset_value", 4'(i), 8'h00);
    chk("wave_reset", {7'h0, wave}, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr8(a[i], d[i]);
      rdc("access", a[i], e[i]);
    end
    for (int i = 1; i < 6; i++) wr8(a[i], 8'h00);
    wr8(OFS_CNT_L, 8'h34);
    rdc("staging", OFS_TEMP, 8'h34);
    wr8(OFS_CNT_H, 8'h12);
    rdc("cnt_low", OFS_CNT_L, 8'h34);
    wr8(OFS_TEMP, 8'h77);
    rdc("cnt_high", OFS_CNT_H, 8'h77);
  endtask
  task automatic t_out();
    logic [7:0] cb [3] = '{8'h31, 8'h21, 8'h11};
    wr8(OFS_CTRL_A, 8'h01);
    for (int i = 0; i < 3; i++) begin
      wr8(OFS_CTRL_B, cb[i]);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("wave_level", {7'h0, wave}, {7'h0, i == 0});
      @(posedge clk);
    end
  endtask
  task automatic t_modes();
    logic f;
    int   s0;
    for (int m = 0; m < 8; m++) begin
      for (int e = 0; e < 2; e++) begin
        if (m == 6) continue;
        cfg(8'(m), {3'h0, 1'(e), 4'h1}, 16'hffff, 16'h0000);
        for (int k = 0; k < 4; k++) begin
          s0 = strobes;
          edge_to(k % 2 == 0, 8);
          case (m)
            2, 3: f = (k % 2 == e);
            4: f = (k % 2 != e);
            5: f = (k == 2 + e);
            default: f = 1'b0;
          endcase
          rdc("flag", OFS_FLAGS, {7'h0, f});
          chk("strobe", 8'(strobes - s0), {7'h0, f});
          if (m == 1) rdc("run", OFS_STATUS, {7'h0, k % 2 == e});
          wr8(OFS_FLAGS, 8'h01);
        end
      end
    end
  endtask
  task automatic t_cap();
    logic [7:0] q;
    cfg(8'h02, 8'h00, 16'hffff, 16'h0000);
    edge_to(1'b1, 8);
    rdc("input_off", OFS_FLAGS, 8'h00);
    edge_to(1'b0, 8);
    wr8(OFS_EVENT_CONTROL, 8'h41);
    edge_to(1'b1, 2);
    edge_to(1'b0, 10);
    rdc("glitch", OFS_FLAGS, 8'h00);
    edge_to(1'b1, 12);
    rdc("filtered", OFS_FLAGS, 8'h01);
    rd8(OFS_CAPTURE_OR_TOP_VALUE_L, q);
    rdc("read_clear", OFS_FLAGS, 8'h00);
    edge_to(1'b0, 8);
  endtask
  task automatic t_single();
    int         l [3];
    int         n;
    logic [7:0] cb [3] = '{8'h16, 8'h56, 8'h16};
    for (int i = 0; i < 3; i++) begin
      cfg(cb[i], {3'h0, 1'(i == 2), 4'h1}, 16'h0010, 16'h0010);
      @(negedge clk);
      chk("shot_idle", {7'h0, wave}, 8'h00);
      @(posedge clk);
      P.set_event(1'b1);
      lat(l[i]);
      repeat (40) @(posedge clk);
      @(negedge clk);
      chk("shot_end", {7'h0, wave}, 8'h00);
      @(posedge clk);
      P.set_event(1'b0);
      lat(n);
      chk("shot_fall", 8'(n), (i == 2) ? 8'(l[0]) : 8'h0c);
      repeat (40) @(posedge clk);
    end
    chk("shot_start", {7'h0, l[0] < 12}, 8'h01);
    chk("shot_early", 8'(l[1] + 1), 8'(l[0]));
    chk("shot_both", 8'(l[2]), 8'(l[0]));
  endtask
  task automatic t_clk();
    logic [7:0] ca [11] = '{8'h01, 8'h03, 8'h05, 8'h07, 8'h00, 8'h01, 8'h01, 8'h41, 8'h45, 8'h01, 8'h01};
    logic [3:0] sl [11] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h2, 4'h1, 4'h1, 4'h1, 4'h4, 4'h8};
    logic [7:0] ex [11] = '{8'h18, 8'h0c, 8'h0c, 8'h00, 8'h00, 8'h00, 8'h00, 8'h18, 8'h00, 8'h00, 8'h03};
    logic [7:0] q0, q1;
    cfg(8'h00, 8'h00, 16'hffff, 16'h0000);
    for (int i = 0; i < 11; i++) begin
      wr8(OFS_CTRL_A, ca[i]);
      {halt, pdown, stby} <= sl[i][2:0];
      rd8(OFS_CNT_L, q0);
      // Clock enable drops only between the reads: the bus would stall otherwise
      hold <= sl[i][3];
      repeat (21) @(posedge clk);
      {hold, halt, pdown, stby} <= 4'h0;
      rd8(OFS_CNT_L, q1);
      chk("tick_rate", q1 - q0, ex[i]);
    end
  endtask
  task automatic t_follow();
    logic [7:0] q;
    for (int i = 0; i < 2; i++) begin
      wr8(OFS_CTRL_A, (i == 0) ? 8'h11 : 8'h01);
      wr16(OFS_CNT_L, 16'h0080);
      P.restart();
      rd8(OFS_CNT_L, q);
      chk("follow", {7'h0, q < 8'h40}, {7'h0, i == 0});
    end
  endtask
  // ==========
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_out();
    t_modes();
    t_cap();
    t_single();
    t_clk();
    t_follow();
    conclude();
  end
endmodule
`default_nettype wire
